/* File: hdl/crosspoint_pkg.sv */
package crosspoint_pkg;

   // Array shape
   localparam int N_SIDE = 16;
   localparam int N_CROSS = 256;
   localparam int ROW_W = 16;
   localparam int FIFO_DEPTH = 16;

   // System clock
   localparam int CLK_NS = 5;

   // Link timing as printed
   localparam int SCLK_MIN_KHZ = 20;
   localparam int SCLK_MAX_KHZ = 5000;
   localparam int SCLK_WIDTH_NS = 100;
   localparam int SCLK_GAP_NS = 100;
   localparam int SCLK_TO_STROBE_NS = 65;
   localparam int STROBE_WIDTH_NS = 65;
   localparam int DEADLINE_US = 5000;

   // Least time in ns to whole cycles, rounded up
   function automatic int ceil_cycles(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   // Derived cycle counts
   localparam int MIN_PERIOD_CYCLES = ceil_cycles(1_000_000 / SCLK_MAX_KHZ);
   localparam int HIGH_CYCLES = ceil_cycles(SCLK_WIDTH_NS);
   localparam int LOW_CYCLES = (MIN_PERIOD_CYCLES - HIGH_CYCLES > ceil_cycles(SCLK_GAP_NS)) ?
      MIN_PERIOD_CYCLES - HIGH_CYCLES : ceil_cycles(SCLK_GAP_NS);
   localparam int SETTLE_CYCLES = ceil_cycles(SCLK_TO_STROBE_NS);
   localparam int STROBE_CYCLES = ceil_cycles(STROBE_WIDTH_NS);
   localparam int SLOW_CYCLES = 1_000_000 / (SCLK_MIN_KHZ * CLK_NS);
   localparam int DEADLINE_CYCLES = DEADLINE_US * 1000 / CLK_NS;

   // Counter widths
   localparam int DIV_W = 6;
   localparam int AGE_W = 20;
   localparam int BITS_W = 9;

   // Latch bit that drives crosspoint (row, col)
   function automatic logic [7:0] cross_index(input logic [3:0] row, input logic [3:0] col);
      return {row, col};
   endfunction

endpackage

/* File: hdl/crosspoint_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface crosspoint_link_if;
   // Shift clock, made by the host
   logic sclk;
   // Serial data, host to device
   logic serial_data_in;
   // Serial data, end of shift register
   logic serial_data_out;
   // Transfer strobe, active low
   logic latch_strobe_n;

   modport device (
      input sclk,
      input serial_data_in,
      input latch_strobe_n,
      output serial_data_out
   );

   modport host (
      output sclk,
      output serial_data_in,
      output latch_strobe_n,
      input serial_data_out
   );
endinterface

`default_nettype wire

/* File: hdl/crosspoint_device.sv */
`timescale 1ns/1ps
`default_nettype none

module crosspoint_device #(
   parameter logic [crosspoint_pkg::AGE_W-1:0] DEADLINE_CYCLES =
      crosspoint_pkg::AGE_W'(crosspoint_pkg::DEADLINE_CYCLES),
   parameter logic [crosspoint_pkg::AGE_W-1:0] SLOW_CYCLES =
      crosspoint_pkg::AGE_W'(crosspoint_pkg::SLOW_CYCLES)
) (
   // Link pins
   crosspoint_link_if.device link,
   // System clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic en,
   // Switch state
   input wire logic [3:0] row_sel,
   output logic [crosspoint_pkg::ROW_W-1:0] row_closed,
   output logic [crosspoint_pkg::N_CROSS-1:0] switch_closed,
   // Status
   output logic latch_done,
   output logic short_load,
   output logic slow_shift,
   output logic late_latch
);

   // Link-domain shift register
   logic [crosspoint_pkg::N_CROSS-1:0] sr_q;

   // Synchronisers for the link clock and strobe pins
   logic sck_s1_q;
   logic sck_s2_q;
   logic sck_s3_q;
   logic stb_s1_q;
   logic stb_s2_q;
   logic stb_s3_q;

   // Event decode
   logic shift_seen;
   logic strobe_low;
   logic strobe_fall;
   logic strobe_rise;

   // Latches and status
   logic [crosspoint_pkg::N_CROSS-1:0] latch_q;
   logic [crosspoint_pkg::ROW_W-1:0] row_closed_q;
   logic [crosspoint_pkg::ROW_W-1:0] row_closed_d;
   logic [crosspoint_pkg::AGE_W-1:0] age_q;
   logic [crosspoint_pkg::BITS_W-1:0] bits_q;
   logic loading_q;
   logic latch_done_q;
   logic short_load_q;
   logic slow_shift_q;
   logic late_latch_q;

   // Shift in on each rising link clock edge; no enable in this domain
   always_ff @(posedge link.sclk or negedge rstn) begin
      if (!rstn) begin
         sr_q <= '0;
      end else begin
         // Bit 0 is newest, so the first bit of a frame ends in bit 255
         sr_q <= {sr_q[crosspoint_pkg::N_CROSS-2:0], link.serial_data_in};
      end
   end

   // End of register drives the cascade output, delayed by 256 shifts
   assign link.serial_data_out = sr_q[crosspoint_pkg::N_CROSS-1];

   // Link clock into the system domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_s1_q <= 1'b0;
         sck_s2_q <= 1'b0;
         sck_s3_q <= 1'b0;
      end else if (en) begin
         sck_s1_q <= link.sclk;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
      end
   end

   // Strobe into the system domain, idle high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stb_s1_q <= 1'b1;
         stb_s2_q <= 1'b1;
         stb_s3_q <= 1'b1;
      end else if (en) begin
         stb_s1_q <= link.latch_strobe_n;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;
      end
   end

   // Edges and strobe level seen after synchronisation
   assign shift_seen = sck_s2_q & ~sck_s3_q;
   assign strobe_low = ~stb_s2_q;
   assign strobe_fall = ~stb_s2_q & stb_s3_q;
   assign strobe_rise = stb_s2_q & ~stb_s3_q;

   // Parallel transfer while strobe is low; register is quiet by then
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         latch_q <= '0;
      end else if (en && strobe_low) begin
         latch_q <= sr_q;
      end
      // Otherwise held regardless of shifting
   end

   // Whole array state, bit index row*16+col
   assign switch_closed = latch_q;

   // Pick one row, columns in bit order
   always_comb begin
      row_closed_d = '0;
      for (int c = 0; c < crosspoint_pkg::N_SIDE; c++) begin
         row_closed_d[c] = latch_q[crosspoint_pkg::cross_index(row_sel, 4'(c))];
      end
   end

   // Registered row view
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         row_closed_q <= '0;
      end else if (en) begin
         row_closed_q <= row_closed_d;
      end
   end

   assign row_closed = row_closed_q;

   // Cycles since the last shift, saturating
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         age_q <= '0;
      end else if (en) begin
         if (shift_seen) begin
            age_q <= '0;
         end else if (age_q != '1) begin
            age_q <= age_q + 1'b1;
         end
      end
   end

   // Shifts since the last transfer, saturating
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bits_q <= '0;
      end else if (en) begin
         if (strobe_rise) begin
            bits_q <= '0;
         end else if (shift_seen && bits_q != '1) begin
            bits_q <= bits_q + 1'b1;
         end
      end
   end

   // A frame is loading from first shift until strobe release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         loading_q <= 1'b0;
      end else if (en) begin
         if (shift_seen) begin
            loading_q <= 1'b1;
         end else if (strobe_rise) begin
            loading_q <= 1'b0;
         end
      end
   end

   // One pulse when a transfer completes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         latch_done_q <= 1'b0;
      end else if (en) begin
         latch_done_q <= strobe_rise;
      end
   end

   // Strobe before a full 256-bit frame; cleared by a later full transfer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         short_load_q <= 1'b0;
      end else if (en && strobe_fall) begin
         short_load_q <= (bits_q < crosspoint_pkg::BITS_W'(crosspoint_pkg::N_CROSS));
      end
   end

   // Gap between shifts too long during a load; set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slow_shift_q <= 1'b0;
      end else if (en) begin
         if (shift_seen && loading_q && age_q > SLOW_CYCLES) begin
            slow_shift_q <= 1'b1;
         end else if (strobe_rise) begin
            slow_shift_q <= 1'b0;
         end
      end
   end

   // Strobe released past the deadline; cleared when a new frame starts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         late_latch_q <= 1'b0;
      end else if (en) begin
         if (strobe_rise && loading_q && age_q > DEADLINE_CYCLES) begin
            late_latch_q <= 1'b1;
         end else if (shift_seen && !loading_q) begin
            late_latch_q <= 1'b0;
         end
      end
   end

   // Status outputs
   assign latch_done = latch_done_q;
   assign short_load = short_load_q;
   assign slow_shift = slow_shift_q;
   assign late_latch = late_latch_q;

endmodule

`default_nettype wire

/* File: hdl/crosspoint_host.sv */
`timescale 1ns/1ps
`default_nettype none

module row_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic en,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic full
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // Wrap bit tells full from empty; depth must be a power of two
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = en & in_valid & ~full;
   assign pop = en & out_ready & out_valid;

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module crosspoint_host (
   // Link pins
   crosspoint_link_if.host link,
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic en,
   // Row words in, row 15 first, column 15 in bit 15
   input wire logic [crosspoint_pkg::ROW_W-1:0] row_data,
   input wire logic row_valid,
   output logic row_ready,
   // Status and cascade echo
   output logic busy,
   output logic frame_done,
   output logic [crosspoint_pkg::ROW_W-1:0] echo_word,
   output logic echo_valid
);

   typedef enum logic [1:0] {IDLE, SHIFT, SETTLE, STROBE} host_state_e;

   host_state_e state_q;
   logic [crosspoint_pkg::DIV_W-1:0] div_q;
   logic [7:0] bit_q;
   logic sclk_q;
   logic strobe_n_q;
   logic done_q;
   logic [crosspoint_pkg::ROW_W-1:0] word_q;
   logic [crosspoint_pkg::ROW_W-1:0] echo_q;
   logic [crosspoint_pkg::ROW_W-1:0] echo_word_q;
   logic echo_valid_q;
   logic serial_data_out_s1_q;
   logic serial_data_out_s2_q;
   logic [crosspoint_pkg::ROW_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_full;
   logic pop;
   logic rise_now;
   logic fall_now;

   // Frame buffer; starts a load only when a whole frame is held
   row_fifo #(.WIDTH(crosspoint_pkg::ROW_W), .DEPTH(crosspoint_pkg::FIFO_DEPTH)) fifo (
      .clk(clk),
      .rstn(rstn),
      .en(en),
      .in_data(row_data),
      .in_valid(row_valid),
      .in_ready(row_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .full(fifo_full)
   );

   // Edge moments of the generated shift clock
   assign rise_now = (state_q == SHIFT) && (div_q == '0) && !sclk_q;
   assign fall_now = (state_q == SHIFT) && (div_q == '0) && sclk_q;
   assign pop = en && fifo_valid && (((state_q == IDLE) && fifo_full) ||
      (fall_now && (bit_q[3:0] == 4'hf) && (bit_q != 8'hff)));

   // Sequencer and clock divider
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= IDLE;
         div_q <= '0;
         bit_q <= '0;
         sclk_q <= 1'b0;
         strobe_n_q <= 1'b1;
      end else if (en) begin
         unique case (state_q)
            IDLE: begin
               if (fifo_full) begin
                  state_q <= SHIFT;
                  bit_q <= '0;
                  div_q <= crosspoint_pkg::DIV_W'(crosspoint_pkg::LOW_CYCLES - 1);
               end
            end
            SHIFT: begin
               // Fixed 200 ns period: within both rate limits
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else if (!sclk_q) begin
                  sclk_q <= 1'b1;
                  div_q <= crosspoint_pkg::DIV_W'(crosspoint_pkg::HIGH_CYCLES - 1);
               end else begin
                  sclk_q <= 1'b0;
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == 8'hff) begin
                     state_q <= SETTLE;
                     div_q <= crosspoint_pkg::DIV_W'(crosspoint_pkg::SETTLE_CYCLES - 1);
                  end else begin
                     div_q <= crosspoint_pkg::DIV_W'(crosspoint_pkg::LOW_CYCLES - 1);
                  end
               end
            end
            SETTLE: begin
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else begin
                  strobe_n_q <= 1'b0;
                  state_q <= STROBE;
                  div_q <= crosspoint_pkg::DIV_W'(crosspoint_pkg::STROBE_CYCLES - 1);
               end
            end
            STROBE: begin
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else begin
                  strobe_n_q <= 1'b1;
                  state_q <= IDLE;
               end
            end
         endcase
      end
   end

   // Frame completion pulse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
      end else if (en) begin
         done_q <= (state_q == STROBE) && (div_q == '0);
      end
   end

   // Outgoing row, most significant column first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word_q <= '0;
      end else if (pop) begin
         word_q <= fifo_data;
      end else if (en && fall_now) begin
         word_q <= {word_q[crosspoint_pkg::ROW_W-2:0], 1'b0};
      end
   end

   // Serial output of the far end into this domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_data_out_s1_q <= 1'b0;
         serial_data_out_s2_q <= 1'b0;
      end else if (en) begin
         serial_data_out_s1_q <= link.serial_data_out;
         serial_data_out_s2_q <= serial_data_out_s1_q;
      end
   end

   // Collect the bits pushed out of the chain, one word per row
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         echo_q <= '0;
         echo_word_q <= '0;
         echo_valid_q <= 1'b0;
      end else if (en) begin
         echo_valid_q <= 1'b0;
         if (rise_now) begin
            echo_q <= {echo_q[crosspoint_pkg::ROW_W-2:0], serial_data_out_s2_q};
         end
         if (fall_now && (bit_q[3:0] == 4'hf)) begin
            echo_word_q <= echo_q;
            echo_valid_q <= 1'b1;
         end
      end
   end

   // Pins and status
   assign link.sclk = sclk_q;
   assign link.serial_data_in = word_q[crosspoint_pkg::ROW_W-1];
   assign link.latch_strobe_n = strobe_n_q;
   assign busy = (state_q != IDLE);
   assign frame_done = done_q;
   assign echo_word = echo_word_q;
   assign echo_valid = echo_valid_q;
endmodule

`default_nettype wire

/* File: verif/crosspoint_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module crosspoint_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link signals
   input wire logic sclk,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic latch_strobe_n
);
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic [7:0] st_q;
   logic [8:0] rise_q;
   logic sclk_p_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // Phase widths and rises since the last strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hi_q <= '0;
         lo_q <= '0;
         st_q <= '0;
         rise_q <= '0;
         sclk_p_q <= 1'b0;
      end else begin
         sclk_p_q <= sclk;
         hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
         lo_q <= sclk ? 8'h00 : ((lo_q == 8'hff) ? lo_q : lo_q + 8'h01);
         st_q <= latch_strobe_n ? 8'h00 : st_q + 8'h01;
         rise_q <= !latch_strobe_n ? 9'h000 : rise_q + 9'(sclk & ~sclk_p_q);
      end
   end

   sclk_high_width_a: assert property ($fell(sclk) |-> hi_q == 8'(crosspoint_pkg::HIGH_CYCLES))
      else $error("shift clock high phase has the wrong width");
   sclk_low_width_a: assert property ($rose(sclk) |-> lo_q >= 8'(crosspoint_pkg::LOW_CYCLES))
      else $error("shift clock low phase too short");
   data_hold_a: assert property (sclk && $past(sclk) |-> $stable(serial_data_in))
      else $error("serial data moved while shift clock high");
   strobe_quiet_a: assert property (!latch_strobe_n |-> !sclk)
      else $error("shift clock high during strobe");
   strobe_width_a: assert property ($rose(latch_strobe_n) |-> st_q == 8'(crosspoint_pkg::STROBE_CYCLES))
      else $error("strobe low phase has the wrong width");
   strobe_settle_a: assert property ($fell(latch_strobe_n) |-> lo_q >= 8'(crosspoint_pkg::SETTLE_CYCLES))
      else $error("strobe came too soon after last shift");
   frame_count_a: assert property ($fell(latch_strobe_n) |-> rise_q == 9'(crosspoint_pkg::N_CROSS))
      else $error("strobe after a wrong number of shifts");
   strobe_deadline_a: assert property ($fell(sclk) && rise_q == 9'h100 |-> ##[1:40] $rose(latch_strobe_n))
      else $error("strobe not completed after full load");
   echo_edge_a: assert property ($changed(serial_data_out) |-> sclk)
      else $error("serial output moved outside a shift");
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b1;
   logic [3:0] row_sel = 4'h0;
   logic [15:0] row_data = 16'h0000;
   logic row_valid = 1'b0;
   logic row_ready, busy, frame_done, echo_valid, latch_done;
   logic [15:0] echo_word, row_closed;
   logic [255:0] switch_closed, sw2;
   logic short_load, slow_shift, late_latch, short2, slow2, late2;
   logic sclk2 = 1'b0;
   logic sin2 = 1'b0;
   logic stb2_n = 1'b1;
   logic [9:0] b2;
   logic [31:0] seed = 32'h0001_5596;
   logic [15:0] frames [3][16];
   logic [15:0] echo_q [$];
   int miscompares = 0;
   int tests_run = 0;
   int done_cnt = 0;
   int ldone_cnt = 0;

   // System clock
   always #2.5 clk = ~clk;

   // Joined ends, and a second device fed by the bench
   crosspoint_link_if link();
   crosspoint_link_if link2();
   assign link2.sclk = sclk2;
   assign link2.serial_data_in = sin2;
   assign link2.latch_strobe_n = stb2_n;

   crosspoint_host i_crosspoint_host (.link(link), .clk(clk), .rstn(rstn), .en(en),
      .row_data(row_data), .row_valid(row_valid), .row_ready(row_ready), .busy(busy),
      .frame_done(frame_done), .echo_word(echo_word), .echo_valid(echo_valid));
   crosspoint_device #(.DEADLINE_CYCLES(20'h0_0190), .SLOW_CYCLES(20'h0_003c))
      i_crosspoint_device (.link(link), .clk(clk), .rstn(rstn), .en(en), .row_sel(row_sel),
      .row_closed(row_closed), .switch_closed(switch_closed), .latch_done(latch_done),
      .short_load(short_load), .slow_shift(slow_shift), .late_latch(late_latch));
   crosspoint_device #(.DEADLINE_CYCLES(20'h0_0190), .SLOW_CYCLES(20'h0_003c))
      i_crosspoint_device_2 (.link(link2), .clk(clk), .rstn(rstn), .en(en), .row_sel(row_sel),
      .row_closed(), .switch_closed(sw2), .latch_done(), .short_load(short2),
      .slow_shift(slow2), .late_latch(late2));
   crosspoint_properties i_crosspoint_properties (.clk(clk), .rstn(rstn), .sclk(link.sclk),
      .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
      .latch_strobe_n(link.latch_strobe_n));

   // Count completions, gather echoed rows
   always @(posedge clk) begin
      if (frame_done === 1'b1) done_cnt <= done_cnt + 1;
      if (latch_done === 1'b1) ldone_cnt <= ldone_cnt + 1;
      if (echo_valid === 1'b1) echo_q.push_back(echo_word);
   end

   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic timeout(input string n);
      miscompares++;
      $display("mismatch %s expected handshake seen timeout", n);
      end_sim();
   endtask

   // Push one frame of 16 row words, holding each until taken
   task automatic push_frame(input int f);
      int n;
      for (int w = 0; w < 16; w++) begin
         row_data = frames[f][w];
         row_valid = 1'b1;
         n = 0;
         while (row_ready !== 1'b1 && n < 30000) begin
            @(posedge clk);
            #1;
            n++;
         end
         if (row_ready !== 1'b1) timeout("row_ready");
         @(posedge clk);
         #1;
      end
      row_valid = 1'b0;
   endtask

   task automatic wait_done(input int k);
      int n;
      n = 0;
      while (done_cnt < k && n < 30000) begin
         @(posedge clk);
         n++;
      end
      if (done_cnt < k) timeout("frame_done");
      #1;
   endtask

   // Every row through both views of the latches
   task automatic check_frame(input int f);
      for (int r = 0; r < 16; r++) begin
         row_sel = 4'(r);
         @(posedge clk);
         #1;
         chk_word("row_closed", frames[f][15-r], row_closed);
         chk_word("switch_closed", frames[f][15-r], switch_closed[r*16 +: 16]);
      end
      chk_bit("short_load", 1'b0, short_load);
      chk_bit("slow_shift", 1'b0, slow_shift);
      chk_bit("late_latch", 1'b0, late_latch);
      chk_word("latch_done", 16'(done_cnt), 16'(ldone_cnt));
   endtask

   // One bench-made shift at the 15 ns link period
   task automatic bit2(input logic b, input realtime gap);
      #(gap);
      sin2 = b;
      #4;
      sclk2 = 1'b1;
      #7.5;
      sclk2 = 1'b0;
      #3.5;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1;
      rstn = 1'b1;
      for (int f = 0; f < 3; f++) begin
         for (int w = 0; w < 16; w++) begin
            frames[f][w] = (f != 1) ? xs() : (w == 0) ? 16'hffff : (w == 15) ? 16'h0000 :
               16'h0001 << w;
         end
      end
      // Faulty loads on the second link: short, slow, late
      #1.3;
      b2 = 10'(xs());
      for (int k = 9; k >= 0; k--) bit2(b2[k], (k == 4) ? 400.0 : 0.0);
      #50;
      chk_bit("slow_shift", 1'b1, slow2);
      stb2_n = 1'b0;
      #40;
      chk_word("switch_closed", {6'h00, b2}, sw2[15:0]);
      chk_bit("short_load", 1'b1, short2);
      stb2_n = 1'b1;
      #50;
      for (int k = 2; k >= 0; k--) bit2(k != 1, 0.0);
      #3000;
      stb2_n = 1'b0;
      #50;
      stb2_n = 1'b1;
      #50;
      chk_bit("late_latch", 1'b1, late2);
      chk_word("switch_closed", {3'h0, b2, 3'h5}, sw2[15:0]);
      // Back-to-back frames through the joined ends
      @(posedge clk);
      #1;
      push_frame(0);
      chk_bit("row_ready", 1'b0, row_ready);
      push_frame(1);
      wait_done(1);
      repeat (3000) @(posedge clk);
      #1;
      chk_bit("busy", 1'b1, busy);
      check_frame(0);
      wait_done(2);
      check_frame(1);
      // Enable low freezes the row view
      en = 1'b0;
      row_sel = 4'h0;
      @(posedge clk);
      #1;
      chk_word("row_closed", frames[1][0], row_closed);
      en = 1'b1;
      push_frame(2);
      wait_done(3);
      check_frame(2);
      chk_bit("busy", 1'b0, busy);
      chk_word("echo_count", 16'h0030, 16'(echo_q.size()));
      for (int i = 0; i < 48 && i < echo_q.size(); i++) begin
         chk_word("echo_word", (i < 16) ? 16'h0000 : frames[i/16-1][i%16], echo_q[i]);
      end
      end_sim();
   end
endmodule

`default_nettype wire
